//--- bpg_pkg.sv
package bpg_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_SEED_BYTE3   = 8'h00;
    localparam logic [7:0] IDX_SEED_BYTE2   = 8'h01;
    localparam logic [7:0] IDX_SEED_BYTE1   = 8'h02;
    localparam logic [7:0] IDX_SEED_BYTE0   = 8'h03;
    localparam logic [7:0] IDX_PAT_LENGTH   = 8'h04;
    localparam logic [7:0] IDX_FB_TAP_SEL   = 8'h05;
    localparam logic [7:0] IDX_PAT_CONTROL  = 8'h06;
    localparam logic [7:0] IDX_ERR_INS_CTRL = 8'h07;
    localparam logic [7:0] IDX_BIT_COUNT3   = 8'h08;
    localparam logic [7:0] IDX_BIT_COUNT2   = 8'h09;
    localparam logic [7:0] IDX_BIT_COUNT1   = 8'h0A;
    localparam logic [7:0] IDX_BIT_COUNT0   = 8'h0B;
    localparam logic [7:0] IDX_STATUS       = 8'h14;

    // pattern_control fields
    localparam int PCTL_TX_LOAD     = 7;
    localparam int PCTL_ZERO_SUPP   = 6;
    localparam int PCTL_PAT_SELECT  = 5;
    localparam int PCTL_LATCH_COUNT = 4;

    // error_insert_ctrl fields
    localparam int EIC_TX_INVERT    = 5;
    localparam int EIC_RX_INVERT    = 4;
    localparam int EIC_SINGLE_ERR   = 3;
    localparam int EIC_RATE_LSB     = 0;
    localparam int EIC_WIDTH        = 6;

    // status fields
    localparam int STAT_SYNC        = 0;
    localparam int STAT_BC_OVF      = 2;

    // reset values
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;

    // zero suppression: longest run of zeros allowed on the line
    localparam logic [3:0]  ZERO_RUN_MAX = 4'hE;

    // bit intervals between automatic errors, one decade per rate code
    localparam logic [23:0] RATE_E1 = 24'h00_000A;
    localparam logic [23:0] RATE_E2 = 24'h00_0064;
    localparam logic [23:0] RATE_E3 = 24'h00_03E8;
    localparam logic [23:0] RATE_E4 = 24'h00_2710;
    localparam logic [23:0] RATE_E5 = 24'h01_86A0;
    localparam logic [23:0] RATE_E6 = 24'h0F_4240;
    localparam logic [23:0] RATE_E7 = 24'h98_9680;

    // synchronised pin inputs, one bit each
    typedef struct packed {
        logic tclk;
        logic rclk;
        logic tx_load;
        logic latch_counts;
        logic rx_count_disable;
        logic rx_sync;
    } bpg_pins_t;

    // interval for a rate code; zero means no automatic insertion
    function automatic logic [23:0] decade_limit(input logic [2:0] code);
        case (code)
            3'h1:    decade_limit = RATE_E1;
            3'h2:    decade_limit = RATE_E2;
            3'h3:    decade_limit = RATE_E3;
            3'h4:    decade_limit = RATE_E4;
            3'h5:    decade_limit = RATE_E5;
            3'h6:    decade_limit = RATE_E6;
            3'h7:    decade_limit = RATE_E7;
            default: decade_limit = 24'h00_0000;
        endcase
    endfunction : decade_limit

endpackage : bpg_pkg

//--- bpg_top.sv
// Operation
// (R1) rate code 0 off, 1..7 one error per decade
// (R2) select low: rotate seed, no feedback
// (R3) quasi-random needs twenty stages plus zero suppression
// (R4) loop deactivate: same taps, both inversions set
// (R5) full 32 stages, no period correction applied
// (R6) feedback tap register at index 05
// (R7) pattern length register at index 04
// (R8) seed bytes at 00..03, msb first
// (R9) transmit inversion is error control bit 5
// (R10) receive inversion is error control bit 4
// (R11) 32-bit receive bit count, bit 31 msb
// (R12) count each receive clock while disable low
// (R13) count halts while sync is lost
// (R14) overflow of count sets sticky flag
// (R15) software clears count by toggling latch
// (R16) latch rising edge copies then clears count
// (R17) load rising edge reloads generator from seed
// (R18) transmit inversion flips every outgoing bit
// (R19) single error edge corrupts exactly one bit
// (R20) free counter inverts one bit per decade
// (R21) count wraps, overflow flag stays until cleared
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps

module bpg_top (
    // apb clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // transmit link
    input  wire logic        tclk,
    input  wire logic        tx_load_pin,
    output logic             tx_data,
    // receive link
    input  wire logic        rclk,
    input  wire logic        rx_count_disable,
    input  wire logic        rx_sync,
    input  wire logic        latch_counts_pin,
    output logic             rx_invert
);

    // whole module state in one record
    typedef struct packed {
        bpg_pkg::bpg_pins_t                sync1;        // first synchroniser stage
        bpg_pkg::bpg_pins_t                sync2;        // second synchroniser stage
        logic                              tclk_prev;    // edge finder for tclk
        logic                              rclk_prev;    // edge finder for rclk
        logic                              load_prev;    // previous combined load
        logic                              latch_prev;   // previous combined latch
        logic                              sbe_prev;     // previous single-error bit
        logic [3:0][7:0]                   seed;         // seed bytes, [3] is msb
        logic [7:0]                        plen;         // pattern_length
        logic [7:0]                        tap;          // feedback_tap_select
        logic [7:0]                        pctl;         // pattern_control
        logic [bpg_pkg::EIC_WIDTH-1:0]     eic;          // error_insert_ctrl
        logic [31:0]                       shreg;        // generator shift register
        logic [3:0]                        zrun;         // zeros sent in a row
        logic [23:0]                       err_cnt;      // bits since last auto error
        logic                              sbe_pend;     // single error waiting
        logic                              tx_data;      // line bit
        logic [31:0]                       bit_cnt;      // internal bit count
        logic [31:0]                       bit_latched;  // readable bit count
        logic                              ovf;          // bit count overflow flag
        logic [31:0]                       prdata;       // apb read data
        logic                              pready;       // apb ready
        logic                              pslverr;      // apb error
    } bpg_state_t;

    bpg_state_t s_q;  // registered state
    bpg_state_t s_d;  // next state

    // raw pins gathered for the synchroniser
    bpg_pkg::bpg_pins_t pins_raw;
    assign pins_raw = '{tclk: tclk, rclk: rclk, tx_load: tx_load_pin,
                        latch_counts: latch_counts_pin,
                        rx_count_disable: rx_count_disable, rx_sync: rx_sync};

    // next-state logic
    always_comb begin
        logic [7:0]  idx;        // register index from byte address
        logic        wr_take;    // write commits this edge
        logic        rd_ovf_clr; // status read clears overflow
        logic        hit;        // address is mapped
        logic [31:0] rdata;      // read mux
        logic [4:0]  msb;        // top stage index of generator
        logic        out_bit;    // generator output
        logic        fb;         // feedback bit
        logic        load_now;   // combined load level
        logic        latch_now;  // combined latch level
        logic        sbe_rise;   // single-error edge
        logic        auto_err;   // automatic error this bit
        logic [23:0] limit;      // interval for current rate
        logic        line_bit;   // bit after errors, before inversion

        s_d        = s_q;
        idx        = {2'b00, paddr[7:2]};
        wr_take    = 1'b0;
        rd_ovf_clr = 1'b0;
        hit        = 1'b1;
        rdata      = bpg_pkg::RST_WORD;
        msb        = s_q.plen[4:0];
        out_bit    = 1'b0;
        fb         = 1'b0;
        auto_err   = 1'b0;
        line_bit   = 1'b0;
        load_now   = 1'b0;
        latch_now  = 1'b0;
        sbe_rise   = 1'b0;
        limit      = bpg_pkg::decade_limit(s_q.eic[bpg_pkg::EIC_RATE_LSB +: 3]);

        // two-flop synchroniser; only sync2 is read by logic
        s_d.sync1 = pins_raw;
        s_d.sync2 = s_q.sync1;

        // register decode, also used for the unmapped answer
        case (idx)
            bpg_pkg::IDX_SEED_BYTE3:   rdata[7:0] = s_q.seed[3];          // [R8]
            bpg_pkg::IDX_SEED_BYTE2:   rdata[7:0] = s_q.seed[2];          // [R8]
            bpg_pkg::IDX_SEED_BYTE1:   rdata[7:0] = s_q.seed[1];          // [R8]
            bpg_pkg::IDX_SEED_BYTE0:   rdata[7:0] = s_q.seed[0];          // [R8]
            bpg_pkg::IDX_PAT_LENGTH:   rdata[7:0] = s_q.plen;             // [R7]
            bpg_pkg::IDX_FB_TAP_SEL:   rdata[7:0] = s_q.tap;              // [R6]
            bpg_pkg::IDX_PAT_CONTROL:  rdata[7:0] = s_q.pctl;
            bpg_pkg::IDX_ERR_INS_CTRL: rdata[bpg_pkg::EIC_WIDTH-1:0] = s_q.eic;
            bpg_pkg::IDX_BIT_COUNT3:   rdata[7:0] = s_q.bit_latched[31:24]; // [R11]
            bpg_pkg::IDX_BIT_COUNT2:   rdata[7:0] = s_q.bit_latched[23:16];
            bpg_pkg::IDX_BIT_COUNT1:   rdata[7:0] = s_q.bit_latched[15:8];
            bpg_pkg::IDX_BIT_COUNT0:   rdata[7:0] = s_q.bit_latched[7:0];
            bpg_pkg::IDX_STATUS: begin
                rdata[bpg_pkg::STAT_SYNC]   = s_q.sync2.rx_sync;
                rdata[bpg_pkg::STAT_BC_OVF] = s_q.ovf;
            end
            default:                   hit = 1'b0;
        endcase
        // paddr bits 1:0 are ignored; words are aligned

        // apb: setup captures the answer, the single access cycle commits it
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        if (psel && !penable) begin
            s_d.pready  = 1'b1;
            s_d.pslverr = !hit;
            s_d.prdata  = pwrite ? bpg_pkg::RST_WORD : rdata;
        end
        if (psel && penable && s_q.pready) begin
            wr_take    = pwrite && !s_q.pslverr;
            rd_ovf_clr = !pwrite && (idx == bpg_pkg::IDX_STATUS);
        end

        // register writes; count and status are read-only
        if (wr_take) begin
            case (idx)
                bpg_pkg::IDX_SEED_BYTE3:   s_d.seed[3] = pwdata[7:0];     // [R8]
                bpg_pkg::IDX_SEED_BYTE2:   s_d.seed[2] = pwdata[7:0];     // [R8]
                bpg_pkg::IDX_SEED_BYTE1:   s_d.seed[1] = pwdata[7:0];     // [R8]
                bpg_pkg::IDX_SEED_BYTE0:   s_d.seed[0] = pwdata[7:0];     // [R8]
                bpg_pkg::IDX_PAT_LENGTH:   s_d.plen    = pwdata[7:0];     // [R7]
                bpg_pkg::IDX_FB_TAP_SEL:   s_d.tap     = pwdata[7:0];     // [R6]
                bpg_pkg::IDX_PAT_CONTROL:  s_d.pctl    = pwdata[7:0];
                bpg_pkg::IDX_ERR_INS_CTRL: s_d.eic     = pwdata[bpg_pkg::EIC_WIDTH-1:0]; // [R9] [R10]
                default:                   s_d.pctl    = s_q.pctl;
            endcase
        end

        // edge finders on the synchronised link clocks
        s_d.tclk_prev = s_q.sync2.tclk;
        s_d.rclk_prev = s_q.sync2.rclk;

        // load edge: control bit ORed with the pin
        load_now    = s_q.pctl[bpg_pkg::PCTL_TX_LOAD] | s_q.sync2.tx_load;
        s_d.load_prev = load_now;

        // single error arms on a rising edge and waits for the next bit
        sbe_rise     = s_q.eic[bpg_pkg::EIC_SINGLE_ERR] && !s_q.sbe_prev;
        s_d.sbe_prev = s_q.eic[bpg_pkg::EIC_SINGLE_ERR];
        if (sbe_rise) begin
            s_d.sbe_pend = 1'b1;                                         // [R19]
        end

        if (load_now && !s_q.load_prev) begin
            // reload; the shift register takes the seed msb first
            s_d.shreg   = s_q.seed;                                      // [R17]
            s_d.zrun    = 4'h0;
            s_d.err_cnt = 24'h00_0000;
        end else if (s_q.sync2.tclk && !s_q.tclk_prev) begin
            // one line bit per transmit clock; all 32 stages used as set,
            // so a 32-stage pattern runs its own natural period
            out_bit = s_q.shreg[msb];                                    // [R5]
            if (s_q.pctl[bpg_pkg::PCTL_PAT_SELECT]) begin
                fb = out_bit ^ s_q.shreg[s_q.tap[4:0]];                  // [R6]
            end else begin
                fb = out_bit;                                            // [R2]
            end
            s_d.shreg = {s_q.shreg[30:0], fb};                           // [R7]

            // zero suppression for the quasi-random pattern
            if (s_q.pctl[bpg_pkg::PCTL_ZERO_SUPP] && !out_bit
                    && (s_q.zrun >= bpg_pkg::ZERO_RUN_MAX)) begin
                out_bit = 1'b1;                                          // [R3]
            end
            s_d.zrun = out_bit ? 4'h0 : s_q.zrun + 4'h1;
            if (s_d.zrun > bpg_pkg::ZERO_RUN_MAX) begin
                s_d.zrun = bpg_pkg::ZERO_RUN_MAX;
            end

            // automatic insertion: last bit of each interval is inverted
            if (limit == 24'h00_0000) begin
                s_d.err_cnt = 24'h00_0000;                               // [R1]
            end else if (s_q.err_cnt >= limit - 24'h00_0001) begin
                auto_err    = 1'b1;                                      // [R20]
                s_d.err_cnt = 24'h00_0000;
            end else begin
                s_d.err_cnt = s_q.err_cnt + 24'h00_0001;                 // [R20]
            end

            line_bit = out_bit ^ auto_err ^ s_q.sbe_pend;                // [R19]
            if (s_q.sbe_pend) begin
                s_d.sbe_pend = sbe_rise;
            end
            // inversion applies after errors, as the deactivate code needs
            s_d.tx_data = line_bit ^ s_q.eic[bpg_pkg::EIC_TX_INVERT];    // [R18] [R4]
        end

        // receive bit counter
        if (s_q.sync2.rclk && !s_q.rclk_prev
                && !s_q.sync2.rx_count_disable                           // [R12]
                && s_q.sync2.rx_sync) begin                              // [R13]
            s_d.bit_cnt = s_q.bit_cnt + 32'h0000_0001;                   // [R11] [R21]
            if (s_q.bit_cnt == 32'hFFFF_FFFF) begin
                s_d.ovf = 1'b1;                                          // [R14]
            end
        end

        // a status read clears the flag; a new overflow in the same cycle wins
        if (rd_ovf_clr && !(s_d.ovf && !s_q.ovf)) begin
            s_d.ovf = 1'b0;                                              // [R21]
        end
        if (rd_ovf_clr && s_q.ovf && s_d.bit_cnt == 32'h0000_0000
                && s_q.bit_cnt == 32'hFFFF_FFFF) begin
            s_d.ovf = 1'b1;
        end

        // latch edge: copy the running count out and restart it
        latch_now      = s_q.pctl[bpg_pkg::PCTL_LATCH_COUNT] | s_q.sync2.latch_counts;
        s_d.latch_prev = latch_now;
        if (latch_now && !s_q.latch_prev) begin
            s_d.bit_latched = s_q.bit_cnt;                               // [R16] [R15]
            s_d.bit_cnt     = 32'h0000_0000;                             // [R16]
        end
    end

    // state register; constants only under reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs come straight from state flops
    assign prdata    = s_q.prdata;
    assign pready    = s_q.pready;
    assign pslverr   = s_q.pslverr;
    assign tx_data   = s_q.tx_data;
    assign rx_invert = s_q.eic[bpg_pkg::EIC_RX_INVERT];                  // [R10]

endmodule : bpg_top

//--- bpg_checker.sv
`timescale 1ns/1ps

module bpg_checker (
    // apb clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb slave side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // receive side
    input wire logic        rx_invert
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // completed access and the register index it names
    wire       acc = psel && penable && pready;
    wire [5:0] idx = paddr[7:2];

    ready_after_setup_a: assert property (psel && !penable |=> pready && psel && penable)
        else $error("no answer in the cycle after setup");
    ready_single_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    ready_qualified_a: assert property (pready |-> psel && penable)
        else $error("ready outside an access");
    map_no_error_a: assert property (acc && idx <= 6'h0B |-> !pslverr)
        else $error("mapped register refused");
    unmapped_error_a: assert property (acc && idx > 6'h0B && idx != 6'h14 |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    upper_zero_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    rx_inv_read_a: assert property (acc && !pwrite && idx == 6'h07 |-> prdata[4] == rx_invert)
        else $error("receive inversion pin differs from its bit");
    rx_inv_set_a: assert property (acc && pwrite && idx == 6'h07 && pwdata[4] |-> ##[1:3] rx_invert)
        else $error("receive inversion not set by write");
    rx_inv_clr_a: assert property (acc && pwrite && idx == 6'h07 && !pwdata[4] |-> ##[1:3] !rx_invert)
        else $error("receive inversion not cleared by write");
endmodule : bpg_checker

//--- bpg_link_model.sv
`timescale 1ns/1ps

module bpg_link_model (
    // link clocks made for the block
    output logic      tclk,
    output logic      rclk,
    // line data from the block
    input  wire logic tx_data
);
    // both clocks stand still low between frames
    initial begin
        tclk = 1'b0;
        rclk = 1'b0;
    end

    // n bits; each is sampled just before the next rise, long after the synchroniser delay
    task automatic tx_run(input int n, output int ones);
        ones = 0;
        #3;
        for (int i = 0; i <= n; i++) begin
            if (i > 0) ones += int'(tx_data === 1'b1);
            tclk = 1'b1;
            #40;
            tclk = 1'b0;
            #40;
        end
    endtask : tx_run

    // n receive clock cycles; the lead-in lets level inputs settle through the sync first
    task automatic rx_run(input int n);
        #47;
        repeat (n) begin
            rclk = 1'b1;
            #40;
            rclk = 1'b0;
            #40;
        end
    endtask : rx_run
endmodule : bpg_link_model

//--- test_bert_pattern_setup_and_bit_counter.sv
`timescale 1ns/1ps

module test_bert_pattern_setup_and_bit_counter;
    logic        pclk, presetn, psel, penable, pwrite;  // apb master side
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready, pslverr, tclk, rclk, tx_data, rx_invert;  // design and link model outputs
    logic        tx_load_pin, rx_count_disable, rx_sync, latch_counts_pin;  // pins
    int          n_errors = 0;
    int          checks_done = 0;
    localparam logic [7:0] PCTL = 8'h18;  // pattern_control byte address
    localparam logic [7:0] EIC  = 8'h1C;  // error_insert_ctrl byte address

    bpg_top bpg_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tclk(tclk),
        .tx_load_pin(tx_load_pin), .tx_data(tx_data), .rclk(rclk), .rx_count_disable(rx_count_disable),
        .rx_sync(rx_sync), .latch_counts_pin(latch_counts_pin), .rx_invert(rx_invert));
    bpg_link_model bpg_link_model_i (.tclk(tclk), .rclk(rclk), .tx_data(tx_data));

    always #5 pclk = ~pclk;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one apb transfer; an idle edge first so no strobe is assigned twice in a step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [7:0] ba(input logic [7:0] idx);
        return {idx[5:0], 2'b00};
    endfunction : ba

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, {24'h00_0000, d}, r, e);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, d, e);
        check($sformatf("data at %h", a), d, exp);
        check($sformatf("error at %h", a), {31'h0, e}, 32'h0000_0000);
    endtask : rdchk

    // program the generator, then load it through the pin
    task automatic load(input logic [7:0] s0, input logic [7:0] len, input logic [7:0] tap,
                        input logic [7:0] pctl, input logic [7:0] eic);
        for (int i = 0; i < 3; i++) wr(ba(8'(i)), 8'hFF);
        wr(ba(bpg_pkg::IDX_SEED_BYTE0), s0);
        wr(ba(bpg_pkg::IDX_PAT_LENGTH), len);
        wr(ba(bpg_pkg::IDX_FB_TAP_SEL), tap);
        wr(PCTL, pctl);
        wr(EIC, eic);
        tx_load_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        tx_load_pin <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : load

    task automatic latch_pin;
        @(posedge pclk);
        latch_counts_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        latch_counts_pin <= 1'b0;
    endtask : latch_pin

    task automatic rd_count(output logic [31:0] v);
        logic [31:0] d;
        logic        e;
        repeat (4) @(posedge pclk);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, ba(bpg_pkg::IDX_BIT_COUNT3 + 8'(i)), 32'h0000_0000, d, e);
            v = {v[23:0], d[7:0]};
        end
    endtask : rd_count

    task automatic t_regs;
        logic [31:0] d;
        logic        e;
        for (int i = 0; i < 8; i++) rdchk(ba(8'(i)), {24'h00_0000, bpg_pkg::RST_BYTE});
        for (int i = 0; i < 6; i++) wr(ba(8'(i)), 8'hA0 + 8'(i));
        for (int i = 0; i < 6; i++) rdchk(ba(8'(i)), 32'h0000_00A0 + 32'(i));
        wr(ba(bpg_pkg::IDX_BIT_COUNT0), 8'hFF);
        rdchk(ba(bpg_pkg::IDX_BIT_COUNT0), 32'h0000_0000);
        apb(1'b1, 8'hFC, 32'h0000_00FF, d, e);
        check("unmapped error", {31'h0, e}, 32'h0000_0001);
        apb(1'b0, 8'hFC, 32'h0000_0000, d, e);
        check("unmapped data", d, 32'h0000_0000);
        for (int c = 3; c < 8; c++) begin
            wr(EIC, 8'(c));
            rdchk(EIC, 32'(c));
        end
    endtask : t_regs

    // all-zero repetitive pattern for rate codes 0..2, so each one seen is an inserted error; then feedback must give ones
    task automatic t_auto;
        int ones;
        int exp [3] = '{0, 10, 1};
        for (int c = 0; c < 3; c++) begin
            load(8'hFE, 8'h00, 8'h01, 8'h00, 8'(c));
            bpg_link_model_i.tx_run(100, ones);
            check($sformatf("errors at code %0d", c), 32'(ones), 32'(exp[c]));
        end
        load(8'hFE, 8'h00, 8'h01, 8'h20, 8'h00);
        bpg_link_model_i.tx_run(20, ones);
        check("feedback gives ones", 32'(ones > 0), 32'h1);
    endtask : t_auto

    // a second write of a set bit is no rising edge and must add nothing
    task automatic t_single;
        int ones;
        load(8'hFE, 8'h00, 8'h00, 8'h00, 8'h00);
        for (int k = 0; k < 3; k++) begin
            if (k == 2) wr(EIC, 8'h00);
            wr(EIC, 8'h08);
            bpg_link_model_i.tx_run(20, ones);
            check("single errors", 32'(ones), 32'(k != 1));
        end
    endtask : t_single

    task automatic t_zero_supp;
        int ones;
        load(8'hFE, 8'h00, 8'h00, 8'h40, 8'h00);
        bpg_link_model_i.tx_run(150, ones);
        check("suppressed zeros", 32'(ones), 32'd10);
    endtask : t_zero_supp

    // activation then deactivation settings: the reload must send as many ones as the first run sent zeros
    task automatic t_invert;
        int a;
        int b;
        load(8'hFF, 8'h06, 8'h03, 8'h20, 8'h00);
        bpg_link_model_i.tx_run(64, a);
        wr(EIC, 8'h30);
        wr(PCTL, 8'hA0);
        wr(PCTL, 8'h20);
        bpg_link_model_i.tx_run(64, b);
        check("inverted ones", 32'(b), 32'(64 - a));
        check("rx invert pin", {31'h0, rx_invert}, 32'h1);
        wr(EIC, 8'h00);
    endtask : t_invert

    task automatic t_count;
        logic [31:0] v;
        rx_sync <= 1'b1;
        bpg_link_model_i.rx_run(300);
        wr(PCTL, 8'h10);
        wr(PCTL, 8'h00);
        rd_count(v);
        check("bit count", v, 32'd300);
        rx_count_disable <= 1'b1;
        bpg_link_model_i.rx_run(20);
        latch_pin();
        rd_count(v);
        check("disabled count", v, 32'd0);
        rx_count_disable <= 1'b0;
        rx_sync <= 1'b0;
        bpg_link_model_i.rx_run(20);
        latch_pin();
        rd_count(v);
        check("unsynced count", v, 32'd0);
        rdchk(ba(bpg_pkg::IDX_STATUS), 32'h0000_0000);
        rx_sync <= 1'b1;
        bpg_link_model_i.rx_run(5);
        latch_pin();
        rd_count(v);
        check("count after clear", v, 32'd5);
        rdchk(ba(bpg_pkg::IDX_STATUS), 32'h0000_0001);
    endtask : t_count

    task automatic close_out;
        $display("checks_done %0d n_errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out

    // hang guard: the whole run needs about 8600 cycles
    initial begin
        repeat (40000) @(posedge pclk);
        n_errors++;
        close_out();
    end

    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {tx_load_pin, rx_count_disable, rx_sync, latch_counts_pin} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_auto();
        t_single();
        t_zero_supp();
        t_invert();
        t_count();
        close_out();
    end
endmodule : test_bert_pattern_setup_and_bit_counter

bind bpg_top bpg_checker bpg_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_invert(rx_invert));
